// ---- design/ums_pkg.sv ----
package ums_pkg;

   // Register indices; the byte address on the bus is four times the index.
   localparam logic [5:0] UMS_IDX_STATUS = 6'h1C;
   localparam logic [5:0] UMS_IDX_BUF    = 6'h1D;
   localparam logic [5:0] UMS_IDX_MODE   = 6'h1E;
   localparam logic [5:0] UMS_IDX_CTRL   = 6'h1F;

   // Operating modes held in mode_sel_hi/mode_sel_lo.
   localparam logic [1:0] UMS_MODE_ASYNC = 2'h0;
   localparam logic [1:0] UMS_MODE_MULTI = 2'h1;
   localparam logic [1:0] UMS_MODE_SYNC  = 2'h2;

   // Field positions in mode_reg.
   localparam int UMS_MD_HI  = 7;
   localparam int UMS_MD_LO  = 6;
   localparam int UMS_MD_CS  = 3;
   localparam int UMS_MD_DIR = 1;
   localparam int UMS_MD_SOE = 0;

   // Field positions in control_reg.
   localparam int UMS_CT_PEN = 7;
   localparam int UMS_CT_ODD = 6;
   localparam int UMS_CT_SBL = 5;
   localparam int UMS_CT_CL  = 4;
   localparam int UMS_CT_AD  = 3;
   localparam int UMS_CT_REC = 2;
   localparam int UMS_CT_RXE = 1;
   localparam int UMS_CT_TXE = 0;

   // Field positions in status_flags_reg.
   localparam int UMS_ST_PE   = 7;
   localparam int UMS_ST_ORE  = 6;
   localparam int UMS_ST_FRE  = 5;
   localparam int UMS_ST_RX_FULL_FLAG = 4;
   localparam int UMS_ST_TX_EMPTY_FLAG = 3;
   localparam int UMS_ST_RIE  = 1;
   localparam int UMS_ST_TIE  = 0;

   // Values after reset.
   localparam logic [7:0] UMS_MODE_RST = 8'h00;
   localparam logic [7:0] UMS_CTRL_RST = 8'h00;
   localparam logic       UMS_TX_EMPTY_FLAG_RST = 1'b1;

   // Bit timing in baud ticks.
   localparam logic [3:0] UMS_TICK_LAST = 4'hF;
   localparam logic [3:0] UMS_TICK_MID  = 4'h7;

   localparam logic [1:0] UMS_RESP_OKAY   = 2'h0;
   localparam logic [1:0] UMS_RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {UMS_RX_IDLE, UMS_RX_START, UMS_RX_BITS} ums_rx_state_t;

   typedef struct packed {
      logic rxd;
      logic sclk;
   } ums_pin_in_t;

   typedef struct packed {
      logic txd;
      logic sclk_o;
      logic sclk_oe;
   } ums_pin_out_t;

endpackage

// ---- design/ums_uart.sv ----
// Overview of operation
// - Mode 00 async normal, 01 async multiprocessor, 10 clock-synchronous, 11 reserved.
// - clock_source_sel picks baud_tick when 0, external clock pin rising edges when 1, in async modes only.
// - clock_dir_sel makes the clock pin an output in synchronous mode.
// - tx_pin_select routes port logic (0) or transmitter (1) to the output pin.
// - parity_add appends a parity bit, only in asynchronous normal mode.
// - odd_even_select picks even (0) or odd (1) parity for send and check.
// - stop_len_sel sends one or two stop bits; receiver checks one.
// - char_length_sel picks 7 or 8 bits; 7 only in async normal mode.
// - addr_frame_sel marks multiprocessor frames as data (0) or address (1).
// - Writing 0 to rx_fault_clear clears error flags; the bit reads 1.
// - Clearing rx_on mid-frame finishes and stores that frame first in async modes; a synchronous frame is not stored.
// - Clearing tx_on stops sending only when no data waits in tx_buffer.
// - One address: writes go to tx_buffer, reads return rx_buffer.
// - Parity, overrun and framing flags set on errors and reset to 0.
// - rx_full_flag sets on receive store and clears when rx_buffer is read.
// - tx_empty_flag resets 1, clears on write, sets when shifting starts.
// - rx_irq_en gates rx_full_flag and error flags onto the receive interrupt.
// - tx_irq_en gates tx_empty_flag onto the transmit interrupt.
// - Asynchronous bit time is sixteen baud ticks.
// - Async frames: low start bit, data LSB first, high stop bit.
// - Multiprocessor frames carry the address/data bit in the parity position.
// - Synchronous frames have no start or stop; only overrun is detected.
//
// Chosen here: the AXI4-Lite slave port.
module ums_uart (
   // Clock and reset
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   // AXI4-Lite slave
   input  wire logic [7:0]            s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [7:0]            s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   // Baud timer tick and port logic level
   input  wire logic                  baud_tick,
   input  wire logic                  gpio_out,
   // Serial pins
   input  wire ums_pkg::ums_pin_in_t  pin_in,
   output ums_pkg::ums_pin_out_t      pin_out,
   // Interrupt requests
   output logic                       irq_rx,
   output logic                       irq_tx
);
   import ums_pkg::*;

   typedef struct packed {
      logic [7:0]    mode_reg;
      logic [7:0]    ctrl_reg;
      logic          pe;
      logic          overrun_flag;
      logic          framing_fault;
      logic          rx_full_flag;
      logic          tx_empty_flag;
      logic          rx_irq_en;
      logic          tx_irq_en;
      logic [7:0]    rx_buf;
      logic [7:0]    tx_buf;
      logic [1:0]    rxd_sync;
      logic [1:0]    sck_sync;
      logic          sck_prev;
      logic          tx_busy;
      logic [11:0]   tx_sh;
      logic [3:0]    tx_left;
      logic [3:0]    tx_sub;
      logic          tx_line;
      ums_rx_state_t rx_st;
      logic [3:0]    rx_sub;
      logic [3:0]    rx_left;
      logic [9:0]    rx_sh;
      logic          aw_rdy;
      logic          w_rdy;
      logic          ar_rdy;
      logic          bvalid;
      logic          rvalid;
      logic [5:0]    aw_idx;
      logic [7:0]    wbyte;
      logic          wen;
      logic [1:0]    bresp;
      logic [1:0]    rresp;
      logic [7:0]    rdata;
      ums_pin_out_t  pins;
      logic          irq_rx;
      logic          irq_tx;
   } ums_state_t;

   ums_state_t st_reg;
   ums_state_t st_next;

   logic [1:0]  mode;
   logic        is_async;
   logic        is_sync;
   logic        rxd;
   logic        ext_rise;
   logic        tick;
   logic        sck_rise;
   logic        sck_fall;
   logic        dl8;
   logic        extra;
   logic        tx_load;
   logic        tx_done;
   logic        rx_store;
   logic        rd_buf;
   logic        wr_go;
   logic [7:0]  tx_dat;
   logic [11:0] fr;
   logic [3:0]  tx_n;
   logic [3:0]  rx_k;
   logic [9:0]  rx_al;
   logic [7:0]  rx_dat;
   logic        rx_x;

   always_comb begin
      st_next  = st_reg;
      mode     = st_reg.mode_reg[UMS_MD_HI:UMS_MD_LO];
      is_async = (mode == UMS_MODE_ASYNC) || (mode == UMS_MODE_MULTI);
      is_sync  = (mode == UMS_MODE_SYNC);
      rxd      = st_reg.rxd_sync[1];
      st_next.rxd_sync = {st_reg.rxd_sync[0], pin_in.rxd};
      st_next.sck_sync = {st_reg.sck_sync[0], pin_in.sclk};
      st_next.sck_prev = st_reg.sck_sync[1];
      ext_rise = st_reg.sck_sync[1] && !st_reg.sck_prev;
      tick     = st_reg.mode_reg[UMS_MD_CS] ? ext_rise : baud_tick;
      // Synchronous clock: driven on baud ticks, or taken from the pin.
      if (st_reg.mode_reg[UMS_MD_DIR]) begin
         sck_rise = st_reg.tx_busy && baud_tick && !st_reg.pins.sclk_o;
         sck_fall = st_reg.tx_busy && baud_tick && st_reg.pins.sclk_o;
      end else begin
         sck_rise = ext_rise;
         sck_fall = !st_reg.sck_sync[1] && st_reg.sck_prev;
      end
      // Seven bits only in asynchronous normal mode.
      dl8      = st_reg.ctrl_reg[UMS_CT_CL] || (mode != UMS_MODE_ASYNC);
      // Parity bit only in normal mode; marker bit in multiprocessor mode.
      extra    = (mode == UMS_MODE_ASYNC && st_reg.ctrl_reg[UMS_CT_PEN]) || (mode == UMS_MODE_MULTI);
      tx_dat   = dl8 ? st_reg.tx_buf : {1'b0, st_reg.tx_buf[6:0]};
      // Start low, data LSB first, stop high.
      fr       = 12'hFFF;
      fr[0]    = 1'b0;
      fr[8:1]  = dl8 ? tx_dat : {1'b1, tx_dat[6:0]};
      // Even or odd parity; address/data marker.
      if (extra) begin
         fr[{3'b100, dl8}] = (mode == UMS_MODE_MULTI) ? st_reg.ctrl_reg[UMS_CT_AD]
                                                      : ((^tx_dat) ^ st_reg.ctrl_reg[UMS_CT_ODD]);
      end
      // One or two stop bits on transmit.
      tx_n     = 4'd9 + {3'd0, dl8} + {3'd0, extra} + {3'd0, st_reg.ctrl_reg[UMS_CT_SBL]};
      // Receiver counts data, marker and a single stop bit.
      rx_k     = is_sync ? 4'd8 : 4'd8 + {3'd0, dl8} + {3'd0, extra};
      rx_al    = {rxd, st_reg.rx_sh[9:1]} >> (4'd10 - rx_k);
      rx_dat   = dl8 ? rx_al[7:0] : {1'b0, rx_al[6:0]};
      rx_x     = rx_al[4'd7 + {3'd0, dl8}];
      tx_done  = 1'b0;
      rx_store = 1'b0;
      rd_buf   = 1'b0;
      wr_go    = !st_reg.aw_rdy && !st_reg.w_rdy && !st_reg.bvalid;

      // Transmit engine.
      if (st_reg.tx_busy && is_async) begin
         if (tick) begin
            if (st_reg.tx_sub == UMS_TICK_LAST) begin
               st_next.tx_sub = 4'd0;
               if (st_reg.tx_left == 4'd1) begin
                  st_next.tx_busy = 1'b0;
                  tx_done         = 1'b1;
               end else begin
                  st_next.tx_sh   = {1'b1, st_reg.tx_sh[11:1]};
                  st_next.tx_line = st_reg.tx_sh[1];
                  st_next.tx_left = st_reg.tx_left - 4'd1;
               end
            end else begin
               st_next.tx_sub = st_reg.tx_sub + 4'd1;
            end
         end
      end else if (st_reg.tx_busy) begin
         if (sck_fall) begin
            st_next.tx_line = st_reg.tx_sh[0];
         end
         if (sck_rise) begin
            st_next.tx_sh   = {1'b1, st_reg.tx_sh[11:1]};
            st_next.rx_sh   = {rxd, st_reg.rx_sh[9:1]};
            st_next.tx_left = st_reg.tx_left - 4'd1;
            // Synchronous frame ends after eight clocks with no stop bit.
            if (st_reg.tx_left == 4'd1) begin
               st_next.tx_busy = 1'b0;
               st_next.tx_line = 1'b1;
               tx_done         = 1'b1;
               rx_store        = st_reg.ctrl_reg[UMS_CT_RXE];
            end
         end
      end
      if (is_sync) begin
         st_next.pins.sclk_o = st_reg.pins.sclk_o ^ (sck_rise || sck_fall) & st_reg.mode_reg[UMS_MD_DIR];
      end else begin
         st_next.pins.sclk_o = 1'b1;
      end
      // A waiting byte is sent even after tx_on is cleared mid-frame.
      tx_load = !st_reg.tx_empty_flag && (mode != 2'h3)
                && (st_reg.tx_busy ? tx_done
                   : (st_reg.ctrl_reg[UMS_CT_TXE] || (is_sync && st_reg.ctrl_reg[UMS_CT_RXE])));
      if (tx_load) begin
         st_next.tx_busy = 1'b1;
         st_next.tx_sub  = 4'd0;
         // Byte moves to the shifter, the buffer is free again.
         st_next.tx_empty_flag    = 1'b1;
         if (is_sync) begin
            st_next.tx_sh   = {4'hF, st_reg.tx_buf};
            st_next.tx_left = 4'd8;
         end else begin
            st_next.tx_sh   = fr;
            st_next.tx_line = fr[0];
            st_next.tx_left = tx_n;
         end
      end

      // Asynchronous receive engine.
      unique case (st_reg.rx_st)
         UMS_RX_IDLE: begin
            // Only a new frame waits for rx_on.
            if (is_async && st_reg.ctrl_reg[UMS_CT_RXE] && !rxd) begin
               st_next.rx_st  = UMS_RX_START;
               st_next.rx_sub = 4'd0;
            end
         end
         UMS_RX_START: begin
            // Start must still be low at mid-bit.
            if (tick && st_reg.rx_sub == UMS_TICK_MID) begin
               st_next.rx_st   = rxd ? UMS_RX_IDLE : UMS_RX_BITS;
               st_next.rx_sub  = 4'd0;
               st_next.rx_left = rx_k;
            end else if (tick) begin
               st_next.rx_sub = st_reg.rx_sub + 4'd1;
            end
         end
         UMS_RX_BITS: begin
            if (tick && st_reg.rx_sub == UMS_TICK_LAST) begin
               st_next.rx_sub  = 4'd0;
               st_next.rx_sh   = {rxd, st_reg.rx_sh[9:1]};
               st_next.rx_left = st_reg.rx_left - 4'd1;
               if (st_reg.rx_left == 4'd1) begin
                  st_next.rx_st = UMS_RX_IDLE;
                  rx_store      = 1'b1;
               end
            end else if (tick) begin
               st_next.rx_sub = st_reg.rx_sub + 4'd1;
            end
         end
      endcase

      // AXI4-Lite read channel.
      if (st_reg.rvalid && s_axi_rready) begin
         st_next.rvalid = 1'b0;
         st_next.ar_rdy = 1'b1;
      end
      if (st_reg.ar_rdy && s_axi_arvalid) begin
         st_next.ar_rdy = 1'b0;
         st_next.rvalid = 1'b1;
         st_next.rresp  = UMS_RESP_OKAY;
         unique case (s_axi_araddr[7:2])
            UMS_IDX_STATUS: st_next.rdata = {st_reg.pe, st_reg.overrun_flag, st_reg.framing_fault, st_reg.rx_full_flag,
                                             st_reg.tx_empty_flag, 1'b0, st_reg.rx_irq_en, st_reg.tx_irq_en};
            // Reads of the shared address return rx_buffer.
            UMS_IDX_BUF: begin
               st_next.rdata = st_reg.rx_buf;
               rd_buf        = 1'b1;
            end
            UMS_IDX_MODE: st_next.rdata = st_reg.mode_reg;
            UMS_IDX_CTRL: st_next.rdata = st_reg.ctrl_reg | 8'h04;
            default: begin
               st_next.rdata = 8'h00;
               st_next.rresp = UMS_RESP_SLVERR;
            end
         endcase
      end
      if (rd_buf) begin
         st_next.rx_full_flag = 1'b0;
      end

      // AXI4-Lite write channels.
      if (st_reg.bvalid && s_axi_bready) begin
         st_next.bvalid = 1'b0;
         st_next.aw_rdy = 1'b1;
         st_next.w_rdy  = 1'b1;
      end
      if (st_reg.aw_rdy && s_axi_awvalid) begin
         st_next.aw_rdy = 1'b0;
         st_next.aw_idx = s_axi_awaddr[7:2];
      end
      if (st_reg.w_rdy && s_axi_wvalid) begin
         st_next.w_rdy = 1'b0;
         st_next.wbyte = s_axi_wdata[7:0];
         st_next.wen   = s_axi_wstrb[0];
      end
      if (wr_go) begin
         st_next.bvalid = 1'b1;
         st_next.bresp  = UMS_RESP_OKAY;
         unique case (st_reg.aw_idx)
            UMS_IDX_STATUS: if (st_reg.wen) begin
               st_next.rx_irq_en = st_reg.wbyte[UMS_ST_RIE];
               st_next.tx_irq_en = st_reg.wbyte[UMS_ST_TIE];
            end
            // Writes to the shared address go to tx_buffer.
            UMS_IDX_BUF: if (st_reg.wen) begin
               st_next.tx_buf = st_reg.wbyte;
               st_next.tx_empty_flag   = 1'b0;
            end
            // Mode field lives in the top two bits.
            UMS_IDX_MODE: if (st_reg.wen) begin
               st_next.mode_reg = st_reg.wbyte;
            end
            UMS_IDX_CTRL: if (st_reg.wen) begin
               st_next.ctrl_reg = st_reg.wbyte;
               // Writing 0 clears the error flags.
               if (!st_reg.wbyte[UMS_CT_REC]) begin
                  st_next.pe  = 1'b0;
                  st_next.overrun_flag = 1'b0;
                  st_next.framing_fault = 1'b0;
               end
            end
            default: st_next.bresp = UMS_RESP_SLVERR;
         endcase
      end

      // Error flags set on a stored frame, after any clear.
      if (rx_store) begin
         st_next.rx_buf = rx_dat;
         st_next.rx_full_flag   = 1'b1;
         if (st_reg.rx_full_flag && !rd_buf) begin
            st_next.overrun_flag = 1'b1;
         end
         // Parity check in normal mode only.
         if (mode == UMS_MODE_ASYNC && st_reg.ctrl_reg[UMS_CT_PEN]
             && (((^rx_dat) ^ rx_x) != st_reg.ctrl_reg[UMS_CT_ODD])) begin
            st_next.pe = 1'b1;
         end
         // No framing check in synchronous mode.
         if (is_async && !rxd) begin
            st_next.framing_fault = 1'b1;
         end
      end

      st_next.pins.txd     = st_reg.mode_reg[UMS_MD_SOE] ? st_reg.tx_line : gpio_out;
      // Clock pin drives only in synchronous mode with clock_dir_sel set.
      st_next.pins.sclk_oe = is_sync && st_reg.mode_reg[UMS_MD_DIR];
      st_next.irq_rx = st_reg.rx_irq_en && (st_reg.rx_full_flag || st_reg.pe || st_reg.overrun_flag || st_reg.framing_fault);
      st_next.irq_tx = st_reg.tx_irq_en && st_reg.tx_empty_flag;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_reg           <= '0;
         st_reg.mode_reg  <= UMS_MODE_RST;
         st_reg.ctrl_reg  <= UMS_CTRL_RST;
         st_reg.tx_empty_flag      <= UMS_TX_EMPTY_FLAG_RST;
         st_reg.tx_line   <= 1'b1;
         st_reg.aw_rdy    <= 1'b1;
         st_reg.w_rdy     <= 1'b1;
         st_reg.ar_rdy    <= 1'b1;
         st_reg.pins.txd  <= 1'b1;
         st_reg.pins.sclk_o <= 1'b1;
         st_reg.rx_st     <= UMS_RX_IDLE;
      end else begin
         st_reg <= st_next;
      end
   end

   assign s_axi_awready = st_reg.aw_rdy;
   assign s_axi_wready  = st_reg.w_rdy;
   assign s_axi_bvalid  = st_reg.bvalid;
   assign s_axi_bresp   = st_reg.bresp;
   assign s_axi_arready = st_reg.ar_rdy;
   assign s_axi_rvalid  = st_reg.rvalid;
   assign s_axi_rresp   = st_reg.rresp;
   assign s_axi_rdata   = {24'h00_0000, st_reg.rdata};
   assign pin_out       = st_reg.pins;
   assign irq_rx        = st_reg.irq_rx;
   assign irq_tx        = st_reg.irq_tx;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   rx_full_flag_read_clear_a: assert property (rd_buf && !rx_store |=> !st_reg.rx_full_flag)
      else $error("rx_full_flag not cleared by buffer read");
   err_clear_a: assert property (wr_go && st_reg.aw_idx == UMS_IDX_CTRL && st_reg.wen
         && !st_reg.wbyte[UMS_CT_REC] && !rx_store |=> !(st_reg.pe || st_reg.overrun_flag || st_reg.framing_fault))
      else $error("error flags not cleared");
   tx_empty_flag_write_a: assert property (wr_go && st_reg.aw_idx == UMS_IDX_BUF && st_reg.wen |=> !st_reg.tx_empty_flag)
      else $error("tx_empty_flag not cleared by write");
   tx_empty_flag_load_a: assert property (tx_load && !wr_go |=> st_reg.tx_empty_flag && st_reg.tx_busy)
      else $error("tx_empty_flag not set on shifter load");
   start_bit_a: assert property (tx_load && is_async |=> !st_reg.tx_line ##1 !st_reg.tx_line)
      else $error("start bit not low");
   bit_hold_a: assert property (st_reg.tx_busy && is_async && tick
         && st_reg.tx_sub != UMS_TICK_LAST |=> $stable(st_reg.tx_line))
      else $error("tx line changed inside a bit");
   ore_set_a: assert property (rx_store && st_reg.rx_full_flag && !rd_buf |=> st_reg.overrun_flag && st_reg.rx_full_flag)
      else $error("overrun not flagged");
   irq_tx_gate_a: assert property (!st_reg.tx_irq_en |=> !irq_tx)
      else $error("transmit interrupt not masked");
   irq_rx_path_a: assert property (st_reg.rx_irq_en && st_reg.rx_full_flag ##1 st_reg.rx_irq_en && st_reg.rx_full_flag |-> irq_rx)
      else $error("receive interrupt missing");
   clk_oe_a: assert property (!is_sync |=> !pin_out.sclk_oe)
      else $error("clock pin driven outside synchronous mode");
   txd_gpio_a: assert property (!st_reg.mode_reg[UMS_MD_SOE] ##1 $stable(st_reg.mode_reg)
         |-> pin_out.txd == $past(gpio_out))
      else $error("port level not routed to output pin");

   async_frame_c: cover property (tx_done && is_async);
   sync_frame_c:  cover property (rx_store && is_sync);
   rx_error_c:    cover property (rx_store && is_async && !rxd);
   chained_c:     cover property (tx_done && tx_load);
endmodule

// ---- bench/ums_peer.sv ----
module ums_peer (
   // Lines seen from the remote end
   input  wire logic txd,
   output logic      rxd,
   output logic      sclk
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      rxd = 1'b1;
      sclk = 1'b1;
   end

   // Low start, eight bits LSB first, then the stop bit.
   task automatic send(input logic [7:0] d, input logic stop_v, input logic ext);
      logic [9:0] f;
      f = {stop_v, d, 1'b0};
      for (int i = 0; i < 10; i++) begin
         rxd <= f[i];
         if (ext) begin
            repeat (16) begin
               sclk <= 1'b0;
               #100;
               sclk <= 1'b1;
               #100;
            end
         end else begin
            #(i == 9 && !stop_v ? 500 : 800);
         end
      end
      rxd <= 1'b1;
   endtask

   // Samples eleven bit times from the middle of the start bit.
   task automatic recv(output logic [10:0] b);
      int n;
      b = '1;
      n = 0;
      #12;
      while (txd !== 1'b0 && n < 4000) begin
         #25;
         n++;
      end
      if (n < 4000) begin
         #400;
         for (int i = 0; i < 11; i++) begin
            #800;
            b[i] = txd;
         end
      end
   endtask
endmodule

// ---- bench/tb.sv ----
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import ums_pkg::*;
   localparam logic [7:0] A_ST = {UMS_IDX_STATUS, 2'b00};
   localparam logic [7:0] A_BF = {UMS_IDX_BUF, 2'b00};
   localparam logic [7:0] A_MD = {UMS_IDX_MODE, 2'b00};
   localparam logic [7:0] A_CT = {UMS_IDX_CTRL, 2'b00};
   logic         aclk = 1'b0, aresetn = 1'b0, baud_tick = 1'b0, gpio_out = 1'b1;
   logic         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [7:0]   s_axi_awaddr = '0, s_axi_araddr = '0, v;
   logic [31:0]  s_axi_wdata = '0, s_axi_rdata;
   logic [3:0]   s_axi_wstrb = 4'h1;
   logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]   s_axi_bresp, s_axi_rresp, resp;
   logic         irq_rx, irq_tx, rx_line, sclk_line;
   logic [10:0]  bits;
   ums_pin_out_t pin_out;
   int           err_total = 0;
   int           n_checks = 0;

   ums_uart u_ums_uart (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .baud_tick,
      .gpio_out, .pin_in(ums_pin_in_t'({rx_line, sclk_line})), .pin_out, .irq_rx, .irq_tx);
   ums_peer u_ums_peer (.txd(pin_out.txd), .rxd(rx_line), .sclk(sclk_line));

   always #12.5 aclk = ~aclk;
   always @(posedge aclk) baud_tick <= ~baud_tick;

   task automatic chk(input string nm, input logic [10:0] e, input logic [10:0] g);
      n_checks++;
      if (g !== e) begin
         $display("BAD %s expected %h seen %h", nm, e, g);
         err_total++;
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && n < 50);
      s_axi_bready <= 1'b0;
      resp = s_axi_bresp;
      if (n >= 50) begin
         chk("write_wait", 11'h0, 11'h1);
         stop_test();
      end
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && n < 50);
      s_axi_rready <= 1'b0;
      resp = s_axi_rresp;
      d = s_axi_rdata[7:0];
      if (n >= 50) begin
         chk("read_wait", 11'h0, 11'h1);
         stop_test();
      end
   endtask

   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      rd(a, v);
      chk($sformatf("reg_%h", a), {3'b0, e}, {3'b0, v});
   endtask

   task automatic stop_test;
      $display("Checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      rc(A_ST, 8'h08);
      rc(A_MD, UMS_MODE_RST);
      rc(A_CT, 8'h04);
      gpio_out <= 1'b0;
      repeat (3) @(posedge aclk);
      chk("txd_gpio", 11'h0, {10'h0, pin_out.txd});
      gpio_out <= 1'b1;
      rd(8'h00, v);
      chk("unmapped", {9'h0, UMS_RESP_SLVERR}, {9'h0, resp});
      wr(8'h00, 8'h00);
      chk("unmapped_wr", {9'h0, UMS_RESP_SLVERR}, {9'h0, resp});
      wr(A_MD, 8'h31);
      rc(A_MD, 8'h31);
      wr(A_CT, 8'h13);
      wr(A_ST, 8'h03);
      repeat (3) @(posedge aclk);
      chk("irq_tx", 11'h1, {10'h0, irq_tx});
      fork
         u_ums_peer.recv(bits);
         wr(A_BF, 8'hA5);
      join
      chk("frame_8n1", 11'h7A5, bits);
      rc(A_ST, 8'h0B);
      wr(A_CT, 8'hF3);
      fork
         u_ums_peer.recv(bits);
         wr(A_BF, 8'h01);
      join
      chk("frame_8o2", 11'h601, bits);
      wr(A_CT, 8'h13);
      u_ums_peer.send(8'h3C, 1'b1, 1'b0);
      repeat (5) @(posedge aclk);
      chk("irq_rx", 11'h1, {10'h0, irq_rx});
      rc(A_ST, 8'h1B);
      rc(A_BF, 8'h3C);
      rc(A_ST, 8'h0B);
      u_ums_peer.send(8'h55, 1'b0, 1'b0);
      repeat (5) @(posedge aclk);
      rc(A_ST, 8'h3B);
      wr(A_CT, 8'h13);
      rc(A_ST, 8'h1B);
      rc(A_BF, 8'h55);
      wr(A_CT, 8'h14);
      wr(A_MD, 8'h39);
      wr(A_CT, 8'h13);
      chk("sclk_oe", 11'h0, {10'h0, pin_out.sclk_oe});
      u_ums_peer.send(8'h5A, 1'b1, 1'b1);
      repeat (5) @(posedge aclk);
      rc(A_BF, 8'h5A);
      wr(A_CT, 8'h14);
      wr(A_MD, 8'hB3);
      wr(A_CT, 8'h13);
      chk("sclk_oe_sync", 11'h1, {10'h0, pin_out.sclk_oe});
      wr(A_BF, 8'hC3);
      repeat (60) @(posedge aclk);
      rc(A_ST, 8'h1B);
      rc(A_BF, 8'hFF);
      chk("sclk_idle", 11'h1, {10'h0, pin_out.sclk_o});
      wr(A_CT, 8'h14);
      wr(A_MD, 8'h71);
      wr(A_CT, 8'h13);
      fork
         u_ums_peer.recv(bits);
         wr(A_BF, 8'h96);
      join
      chk("frame_mp", 11'h696, bits);
      stop_test();
   end
endmodule
